// >>> core/lcr_pkg.sv
package lcr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_LANE_RECEIVER_DETECT_CTRL = 8'h23;
    localparam logic [7:0] OFS_EQ = 8'h24;
    localparam logic [7:0] OFS_SWING = 8'h25;
    localparam logic [7:0] OFS_STATUS = 8'h26;
    localparam logic [7:0] RST_LANE_RECEIVER_DETECT_CTRL = 8'h00;
    localparam logic [7:0] RST_EQ = 8'h2f;
    localparam logic [7:0] RST_SWING = 8'had;
    localparam int LANE_RECEIVER_DETECT_CTRL_LO = 2;
    localparam int LANE_RECEIVER_DETECT_CTRL_HI = 3;
    localparam int SCP_BIT = 7;
    localparam int MODE_BIT = 6;
    localparam int SWING_LO = 0;
    localparam int SWING_HI = 2;
    localparam int STATUS_BIT = 7;
    localparam logic [1:0] DET_HIZ = 2'h0;
    localparam logic [1:0] DET_AUTO_LIM = 2'h1;
    localparam logic [1:0] DET_AUTO_FREE = 2'h2;
    localparam logic [1:0] DET_TERM = 2'h3;
    localparam int CLK_HZ = 25_000_000;
    localparam int PROBE_MS = 12;
    localparam int PROBE_CYC = CLK_HZ / 1000 * PROBE_MS;
    localparam int PROBE_MAX = 50;
    typedef enum logic [1:0] {ST_IDLE, ST_PROBE, ST_TERM, ST_STOP} lcr_det_t;
endpackage

// >>> core/lcr_regs.sv
`timescale 1ns/1ps
module lcr_regs #(
    parameter int PROBE_CYCLES = lcr_pkg::PROBE_CYC,
    parameter int PROBE_LIMIT = lcr_pkg::PROBE_MAX
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic regWrite,
    input wire logic [lcr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [lcr_pkg::DATA_W-1:0] regWdata,
    output logic [lcr_pkg::DATA_W-1:0] regRdata,
    input wire logic detOverride,
    input wire logic modeOverride,
    input wire logic [1:0] detPinMode,
    input wire logic modePin,
    input wire logic rxPresent,
    output logic probePulse,
    output logic termEnable,
    output logic [7:0] equalizerSetting,
    output logic [2:0] outputSwing,
    output logic shortProtect,
    output logic laneMode
);
    import lcr_pkg::*;

    logic [7:0] detReg_r, detReg_nxt, eqReg_r, eqReg_nxt, swReg_r, swReg_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    lcr_det_t st_r, st_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic probe_r, probe_nxt, term_r, term_nxt, sc_r, sc_nxt, md_r, md_nxt;
    logic [1:0] effMode, mode_r;

    // Register file
    // Reserved bits are stored as written; software keeps them at their fixed values
    // Read data is registered, so a read shows the addressed register one cycle later
    always_comb begin
        detReg_nxt = detReg_r;
        eqReg_nxt = eqReg_r;
        swReg_nxt = swReg_r;
        if (regWrite) begin
            if (regAddr == OFS_LANE_RECEIVER_DETECT_CTRL) begin
                detReg_nxt = regWdata;
            end else if (regAddr == OFS_EQ) begin
                eqReg_nxt = regWdata;
            end else if (regAddr == OFS_SWING) begin
                swReg_nxt = regWdata;
            end
        end
        rdata_nxt = 8'h00;
        if (regAddr == OFS_LANE_RECEIVER_DETECT_CTRL) begin
            rdata_nxt = detReg_r;
        end else if (regAddr == OFS_EQ) begin
            rdata_nxt = eqReg_r;
        end else if (regAddr == OFS_SWING) begin
            rdata_nxt = swReg_r;
        end else if (regAddr == OFS_STATUS) begin
            rdata_nxt[STATUS_BIT] = term_r;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            detReg_r <= RST_LANE_RECEIVER_DETECT_CTRL;
            eqReg_r <= RST_EQ;
            swReg_r <= RST_SWING;
            rdata_r <= 8'h00;
        end else begin
            detReg_r <= detReg_nxt;
            eqReg_r <= eqReg_nxt;
            swReg_r <= swReg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Source of the detect mode: register only under override
    assign effMode = detOverride ? detReg_r[LANE_RECEIVER_DETECT_CTRL_HI:LANE_RECEIVER_DETECT_CTRL_LO] : detPinMode;

    // Detect engine; a mode change restarts it so a stale count cannot stop a new auto run
    always_comb begin
        st_nxt = st_r;
        tmr_nxt = tmr_r;
        cnt_nxt = cnt_r;
        probe_nxt = 1'b0;
        if (effMode != mode_r) begin
            st_nxt = ST_IDLE;
            tmr_nxt = 32'h0;
            cnt_nxt = 8'h00;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (effMode == DET_TERM) begin
                        st_nxt = ST_TERM;
                    end else if (effMode == DET_AUTO_LIM || effMode == DET_AUTO_FREE) begin
                        st_nxt = ST_PROBE;
                    end
                end
                ST_PROBE: begin
                    if (tmr_r == 32'(PROBE_CYCLES - 1)) begin
                        tmr_nxt = 32'h0;
                        probe_nxt = 1'b1;
                        if (rxPresent) begin
                            st_nxt = ST_TERM;
                        end else if (effMode == DET_AUTO_LIM && cnt_r == 8'(PROBE_LIMIT - 1)) begin
                            st_nxt = ST_STOP;
                        end else if (effMode == DET_AUTO_LIM) begin
                            // Only the limited run counts; a free run would otherwise wrap the counter
                            cnt_nxt = cnt_r + 8'h01;
                        end
                    end else begin
                        tmr_nxt = tmr_r + 32'h1;
                    end
                end
                default: begin
                end
            endcase
        end
        term_nxt = (st_nxt == ST_TERM);
        sc_nxt = swReg_r[SCP_BIT];
        md_nxt = modeOverride ? swReg_r[MODE_BIT] : modePin;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= ST_IDLE;
            tmr_r <= 32'h0;
            cnt_r <= 8'h00;
            probe_r <= 1'b0;
            term_r <= 1'b0;
            sc_r <= 1'b0;
            md_r <= 1'b0;
            mode_r <= DET_HIZ;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            cnt_r <= cnt_nxt;
            probe_r <= probe_nxt;
            term_r <= term_nxt;
            sc_r <= sc_nxt;
            md_r <= md_nxt;
            mode_r <= effMode;
        end
    end


    // Every output is a flop; protect and mode take one extra stage after the register
    assign regRdata = rdata_r;
    assign probePulse = probe_r;
    assign termEnable = term_r;
    assign equalizerSetting = eqReg_r;
    assign outputSwing = swReg_r[SWING_HI:SWING_LO];
    assign shortProtect = sc_r;
    assign laneMode = md_r;


    // Checks
    AST_HIZ_MODE: assert property (@(posedge mclk) disable iff (!reset_n)
        (effMode == DET_HIZ) [*3] |-> !termEnable) else $error("terminated in hi-z mode");
    AST_TERM_MODE: assert property (@(posedge mclk) disable iff (!reset_n)
        (effMode == DET_TERM) [*3] |-> termEnable) else $error("not terminated in mode 11");
    AST_LIMIT: assert property (@(posedge mclk) disable iff (!reset_n)
        cnt_r <= 8'(PROBE_LIMIT)) else $error("probe count past limit");
    AST_STOP_QUIET: assert property (@(posedge mclk) disable iff (!reset_n)
        st_r == ST_STOP |=> !probePulse) else $error("probe after stop");
    AST_DETECT: assert property (@(posedge mclk) disable iff (!reset_n)
        (st_r == ST_PROBE && probe_nxt && rxPresent && effMode == mode_r) |=> termEnable)
        else $error("no termination after detect");
    AST_SPACING: assert property (@(posedge mclk) disable iff (!reset_n)
        probePulse |=> !probePulse [*2]) else $error("probes too close");
    AST_STATUS: assert property (@(posedge mclk) disable iff (!reset_n)
        (regAddr == OFS_STATUS) |=> regRdata[STATUS_BIT] == $past(termEnable))
        else $error("status bit wrong");
    AST_MODE_SRC: assert property (@(posedge mclk) disable iff (!reset_n)
        !modeOverride |=> laneMode == $past(modePin)) else $error("mode not from pin");
    AST_SCP: assert property (@(posedge mclk) disable iff (!reset_n)
        regWrite && regAddr == OFS_SWING |=> ##1 shortProtect == $past(regWdata[SCP_BIT], 2))
        else $error("protect bit not applied");
    AST_EQ: assert property (@(posedge mclk) disable iff (!reset_n)
        regWrite && regAddr == OFS_EQ |=> equalizerSetting == $past(regWdata))
        else $error("eq not written");

    AST_SWING: assert property (@(posedge mclk) disable iff (!reset_n)
        regWrite && regAddr == OFS_SWING |=> outputSwing == $past(regWdata[SWING_HI:SWING_LO]))
        else $error("swing not written");

    AST_FREE_NO_STOP: assert property (@(posedge mclk) disable iff (!reset_n)
        st_r == ST_STOP |-> mode_r == DET_AUTO_LIM)
        else $error("probing stopped outside limited mode");

    AST_STATUS_RO: assert property (@(posedge mclk) disable iff (!reset_n)
        regWrite && regAddr == OFS_STATUS |=> detReg_r == $past(detReg_r) && eqReg_r == $past(eqReg_r)
        && swReg_r == $past(swReg_r)) else $error("status write changed a register");

    AST_SCP_SRC: assert property (@(posedge mclk) disable iff (!reset_n)
        1'b1 |=> shortProtect == $past(swReg_r[SCP_BIT]))
        else $error("protect not from register");

    // Coverage of the main scenarios
    COV_DETECT: cover property (@(posedge mclk) disable iff (!reset_n) $rose(termEnable));
    COV_STOP: cover property (@(posedge mclk) disable iff (!reset_n) st_r == ST_STOP);
    COV_PROBE: cover property (@(posedge mclk) disable iff (!reset_n) probePulse);
    COV_FREE_DET: cover property (@(posedge mclk) disable iff (!reset_n)
        mode_r == DET_AUTO_FREE && $rose(termEnable));
    COV_FIXED: cover property (@(posedge mclk) disable iff (!reset_n)
        mode_r == DET_TERM && termEnable);
endmodule // lcr_regs

// >>> test/lcr_far_rx.sv
`timescale 1ns/1ps
module lcr_far_rx (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic probePulse,
    input wire logic [7:0] attachAfter,
    output logic rxPresent
);
    logic [7:0] seen_r;
    // Receiver powers up late, so only a later probe can find it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) seen_r <= 8'h00;
        else if (probePulse && seen_r != 8'hff) seen_r <= seen_r + 8'h01;
    end
    assign rxPresent = (seen_r >= attachAfter);
endmodule // lcr_far_rx

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import lcr_pkg::*;
    localparam int PC = 10;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic regWrite = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic detOverride = 1'b0;
    logic modeOverride = 1'b0;
    logic [1:0] detPinMode = DET_TERM;
    logic modePin = 1'b0;
    logic [7:0] attachAfter = 8'd60;
    logic [7:0] regRdata, equalizerSetting;
    logic [2:0] outputSwing;
    logic rxPresent, probePulse, termEnable, shortProtect, laneMode;
    int fails = 0, total_checks = 0, cyc = 0, probes = 0, lastCyc = 0;
    always #20 mclk = ~mclk;
    lcr_regs #(.PROBE_CYCLES(PC), .PROBE_LIMIT(PROBE_MAX)) dut (.mclk(mclk), .reset_n(reset_n),
        .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .detOverride(detOverride), .modeOverride(modeOverride), .detPinMode(detPinMode),
        .modePin(modePin), .rxPresent(rxPresent), .probePulse(probePulse), .termEnable(termEnable),
        .equalizerSetting(equalizerSetting), .outputSwing(outputSwing), .shortProtect(shortProtect),
        .laneMode(laneMode));
    lcr_far_rx farRx (.mclk(mclk), .reset_n(reset_n), .probePulse(probePulse),
        .attachAfter(attachAfter), .rxPresent(rxPresent));
    task automatic finish_test;
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (probePulse === 1'b1) begin
            if (probes > 0) chk("probe gap", 8'(PC), 8'(cyc - lastCyc));
            probes++;
            lastCyc = cyc;
        end
        // Ceiling sits well above the longest wait of the sequence
        if (cyc == 6000) begin
            fails++;
            finish_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
        probes = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge mclk);
        regAddr <= a;
        @(posedge mclk);
        #1;
        chk(nm, e, regRdata);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        rd(OFS_LANE_RECEIVER_DETECT_CTRL, RST_LANE_RECEIVER_DETECT_CTRL, "detect reset");
        rd(OFS_EQ, RST_EQ, "eq reset");
        rd(OFS_SWING, RST_SWING, "swing reset");
        rd(8'h30, 8'h00, "unmapped");
        chk("swing out", 8'h05, {5'h00, outputSwing});
        chk("pin term", 8'h01, {7'h00, termEnable});
        for (int i = 0; i < 256; i += 85) begin
            wr(OFS_EQ, 8'(i));
            waitc(1);
            chk("eq out", 8'(i), equalizerSetting);
            rd(OFS_EQ, 8'(i), "eq read");
        end
        modeOverride <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(OFS_SWING, {i[1:0], 3'b101, i[2:0]});
            waitc(2);
            chk("swing", {5'h00, i[2:0]}, {5'h00, outputSwing});
            chk("short prot", {7'h00, i[1]}, {7'h00, shortProtect});
            chk("lane mode", {7'h00, i[0]}, {7'h00, laneMode});
        end
        modeOverride <= 1'b0;
        waitc(3);
        chk("mode pin", 8'h00, {7'h00, laneMode});
        detOverride <= 1'b1;
        wr(OFS_LANE_RECEIVER_DETECT_CTRL, 8'h00);
        waitc(3);
        chk("hiz term", 8'h00, {7'h00, termEnable});
        wr(OFS_STATUS, 8'h80);
        rd(OFS_STATUS, 8'h00, "status ro");
        wr(OFS_LANE_RECEIVER_DETECT_CTRL, 8'h0c);
        waitc(3);
        chk("fixed term", 8'h01, {7'h00, termEnable});
        rd(OFS_STATUS, 8'h80, "status term");
        wr(OFS_LANE_RECEIVER_DETECT_CTRL, 8'h08);
        waitc(50 * PC);
        chk("free early", 8'h00, {7'h00, termEnable});
        waitc(16 * PC);
        chk("free probes", 8'd61, 8'(probes));
        chk("free term", 8'h01, {7'h00, termEnable});
        attachAfter <= 8'hff;
        wr(OFS_LANE_RECEIVER_DETECT_CTRL, 8'h04);
        waitc(PROBE_MAX * PC + 60);
        chk("lim probes", 8'(PROBE_MAX), 8'(probes));
        chk("lim term", 8'h00, {7'h00, termEnable});
        rd(OFS_STATUS, 8'h00, "status hiz");
        finish_test();
    end
endmodule // testbench
